//--- verilog/dctc_consts.vh
// dctc_consts.vh: command codes, field positions, reset values and register offsets
// assumes byte-wide commands and parameters arriving through the wishbone port
// Notes on behaviour
// - offset maps common n to row n+offset
// - display-on forces every pixel to top gray
// - display-off forces every pixel to gray zero
// - inverse shows level 63 minus stored level
// - normal command cancels every display override
// - config bit 0 selects booster, default on
// - config bits 1,2 pick internal common/precharge
// - sleep on disables circuits, floats outputs
// - phase byte gives reset, precharge lengths
// - clock byte low nibble sets divide 1-16
// - clock byte high nibble selects oscillator frequency
// - even entries average their odd neighbours
// - gray entry zero always has zero width
// - linear preset loads entry n as 2n-1
// - precharge codes apply only with internal source
// - common level code applies only when internal
// - three 8-bit per-colour contrast values
// - 4-bit master current, power-on all ones
// - mux ratio 16-132, enables follow the offset
// - line command takes coordinates then colours
// - rectangle outline, fill only when enabled
`ifndef DCTC_CONSTS_VH
`define DCTC_CONSTS_VH

`define DCTC_CMD_LINE     8'h83
`define DCTC_CMD_RECT     8'h84
`define DCTC_CMD_FILL     8'h92
`define DCTC_CMD_OFFSET   8'hA2
`define DCTC_CMD_ALL_OFF  8'hA4
`define DCTC_CMD_ALL_ON   8'hA5
`define DCTC_CMD_NORMAL   8'hA6
`define DCTC_CMD_INVERSE  8'hA7
`define DCTC_CMD_MCFG     8'hAD
`define DCTC_CMD_SLEEP_ON 8'hAE
`define DCTC_CMD_DISP_ON  8'hAF
`define DCTC_CMD_PHASE    8'hB1
`define DCTC_CMD_CLOCK    8'hB3
`define DCTC_CMD_GRAY     8'hB8
`define DCTC_CMD_LINEAR   8'hB9
`define DCTC_CMD_PRECH    8'hBB
`define DCTC_CMD_COMH     8'hBE
`define DCTC_CMD_CONTRAST 8'hC1
`define DCTC_CMD_MASTER   8'hC7
`define DCTC_CMD_MUX      8'hCA

`define DCTC_MODE_NORMAL  2'h0
`define DCTC_MODE_ALL_ON  2'h1
`define DCTC_MODE_ALL_OFF 2'h2
`define DCTC_MODE_INVERSE 2'h3

`define DCTC_GRAY_MAX     6'h3F
`define DCTC_COMMONS      9'h084
`define DCTC_MUX_MIN      8'h0F
`define DCTC_ODD_ENTRIES  6'h20

`define DCTC_MCFG_BOOST   0
`define DCTC_MCFG_COMH    1
`define DCTC_MCFG_PRECH   2
`define DCTC_FILL_BIT     0

`define DCTC_RST_MCFG     3'h1
`define DCTC_RST_PHASE    8'h74
`define DCTC_RST_CLOCK    8'hD0
`define DCTC_RST_MUX      8'h83
`define DCTC_RST_OFFSET   8'h00
`define DCTC_RST_CONTRAST 8'h80
`define DCTC_RST_MASTER   4'hF
`define DCTC_RST_PRECH    8'h1C
`define DCTC_RST_COMH     8'h1C

`define DCTC_ADR_CMD      6'h00
`define DCTC_ADR_DATA     6'h01
`define DCTC_ADR_STATUS   6'h02
`define DCTC_ADR_CONFIG   6'h03
`define DCTC_ADR_LEVELS   6'h04

`endif

//--- verilog/dctc_top.v
// dctc_top.v: command decoder, settings store, display clock, gray table and pixel path
// assumes a wishbone classic master feeding bytes and a scan engine asking per common/pixel
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "dctc_consts.vh"

module dctc_top (
	input  wire        REF_CLK,
	input  wire        ARST_N,
	input  wire        CLK_EN,
	input  wire [7:0]  WB_ADR_I,
	input  wire [31:0] WB_DAT_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire        WB_WE_I,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire        CLOCK_SOURCE_SELECT_PIN,
	input  wire [7:0]  COM_INDEX,
	input  wire [5:0]  PIXEL_GRAY,
	output reg  [7:0]  ROW_ADDR,
	output reg         COM_ENABLE,
	output reg  [5:0]  DRIVE_GRAY,
	output reg  [7:0]  GRAY_PULSE_WIDTH,
	output reg         DCLK_EN,
	output wire        OSC_INTERNAL_EN,
	output wire [3:0]  OSC_FREQ_SEL,
	output wire [4:0]  RESET_PHASE_LEN,
	output wire [4:0]  PRECHARGE_PHASE_LEN,
	output wire        PANEL_ON,
	output wire        BOOSTER_EN,
	output wire        COMMON_HIGH_INT_EN,
	output wire        PRECHARGE_INT_EN,
	output wire        OUTPUTS_HIZ,
	output wire [7:0]  PRECHARGE_LEVEL_A,
	output wire [7:0]  PRECHARGE_LEVEL_B,
	output wire [7:0]  PRECHARGE_LEVEL_C,
	output wire [7:0]  COMMON_HIGH_LEVEL,
	output wire [7:0]  CONTRAST_A,
	output wire [7:0]  CONTRAST_B,
	output wire [7:0]  CONTRAST_C,
	output wire [3:0]  MASTER_CURRENT,
	output reg         DRAW_LINE_STB,
	output reg         DRAW_RECT_STB,
	output reg         DRAW_FILL_EN,
	output reg  [7:0]  DRAW_COL_START,
	output reg  [7:0]  DRAW_ROW_START,
	output reg  [7:0]  DRAW_COL_END,
	output reg  [7:0]  DRAW_ROW_END,
	output reg  [17:0] DRAW_OUTLINE_COLOR,
	output reg  [17:0] DRAW_FILL_COLOR
);

	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_PARAM = 2'b10;

	reg         rst_meta_reg;
	reg         rst_sync_reg;
	wire        rst_n;

	reg  [1:0]  state_reg;
	reg  [7:0]  cmd_reg;
	reg  [5:0]  pcount_reg;
	reg  [7:0]  pbuf_reg [0:9];
	reg  [7:0]  stage_reg [0:31];
	reg  [7:0]  odd_tab_reg [0:31];

	reg  [7:0]  offset_reg;
	reg  [7:0]  mux_reg;
	reg  [1:0]  mode_reg;
	reg  [2:0]  mcfg_reg;
	reg         disp_on_reg;
	reg  [7:0]  phase_reg;
	reg  [7:0]  clock_reg;
	reg  [7:0]  prech_a_reg;
	reg  [7:0]  prech_b_reg;
	reg  [7:0]  prech_c_reg;
	reg  [7:0]  comh_reg;
	reg  [7:0]  con_a_reg;
	reg  [7:0]  con_b_reg;
	reg  [7:0]  con_c_reg;
	reg  [3:0]  master_reg;
	reg         fill_reg;
	reg  [3:0]  div_cnt_reg;

	wire        wb_take;
	wire        wr_cmd;
	wire        wr_data;
	wire [7:0]  wr_byte;
	wire [5:0]  need;
	wire        last_param;
	integer     i;
	integer     j;

	// number of parameter bytes each command expects; unknown commands take none
	function [5:0] param_count;
		input [7:0] cmd;
		begin
			case (cmd)
				`DCTC_CMD_LINE:     param_count = 6'h07;
				`DCTC_CMD_RECT:     param_count = 6'h0A;
				`DCTC_CMD_GRAY:     param_count = `DCTC_ODD_ENTRIES;
				`DCTC_CMD_PRECH:    param_count = 6'h03;
				`DCTC_CMD_CONTRAST: param_count = 6'h03;
				`DCTC_CMD_FILL,
				`DCTC_CMD_OFFSET,
				`DCTC_CMD_MCFG,
				`DCTC_CMD_PHASE,
				`DCTC_CMD_CLOCK,
				`DCTC_CMD_COMH,
				`DCTC_CMD_MASTER,
				`DCTC_CMD_MUX:      param_count = 6'h01;
				default:            param_count = 6'h00;
			endcase
		end
	endfunction

	// packs three colour bytes sent in C, B, A order into one 18-bit word
	function [17:0] pack_color;
		input [7:0] c;
		input [7:0] b;
		input [7:0] a;
		begin
			pack_color = {c[5:0], b[5:0], a[5:0]};
		end
	endfunction

	always @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	// one wait state: the access is taken in the cycle before ack rises
	assign wb_take    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_cmd     = wb_take & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I[7:2] == `DCTC_ADR_CMD);
	assign wr_data    = wb_take & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I[7:2] == `DCTC_ADR_DATA);
	assign wr_byte    = WB_DAT_I[7:0];
	assign need       = param_count(cmd_reg);
	assign last_param = wr_data & (state_reg == ST_PARAM) & (pcount_reg + 6'h01 == need);

	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end
		else if (CLK_EN)
		begin
			WB_ACK_O <= wb_take;
			if (wb_take & ~WB_WE_I)
			begin
				case (WB_ADR_I[7:2])
					`DCTC_ADR_STATUS: WB_DAT_O <= {16'h0000, cmd_reg, pcount_reg,
						state_reg == ST_PARAM, disp_on_reg};
					`DCTC_ADR_CONFIG: WB_DAT_O <= {clock_reg, phase_reg, mux_reg,
						1'b0, fill_reg, mode_reg, 1'b0, mcfg_reg};
					`DCTC_ADR_LEVELS: WB_DAT_O <= {offset_reg, con_c_reg, con_b_reg, con_a_reg};
					default:          WB_DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// command sequencer: a command byte always restarts it, abandoning a partial command
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg  <= ST_IDLE;
			cmd_reg    <= 8'h00;
			pcount_reg <= 6'h00;
			for (j = 0; j < 10; j = j + 1)
				pbuf_reg[j] <= 8'h00;
			for (j = 0; j < 32; j = j + 1)
				stage_reg[j] <= 8'h00;
		end
		else if (CLK_EN)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (wr_cmd)
					begin
						cmd_reg    <= wr_byte;
						pcount_reg <= 6'h00;
						if (param_count(wr_byte) != 6'h00)
							state_reg <= ST_PARAM;
					end
				end
				ST_PARAM:
				begin
					if (wr_cmd)
					begin
						cmd_reg    <= wr_byte;
						pcount_reg <= 6'h00;
						if (param_count(wr_byte) == 6'h00)
							state_reg <= ST_IDLE;
					end
					else if (wr_data)
					begin
						if (cmd_reg == `DCTC_CMD_GRAY)
							stage_reg[pcount_reg[4:0]] <= wr_byte;
						else if (pcount_reg < 6'h0A)
							pbuf_reg[pcount_reg[3:0]] <= wr_byte;
						if (last_param)
						begin
							pcount_reg <= 6'h00;
							state_reg  <= ST_IDLE;
						end
						else
							pcount_reg <= pcount_reg + 6'h01;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// settings are applied in the cycle that takes the last parameter byte, or the command byte for commands without parameters
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			offset_reg  <= `DCTC_RST_OFFSET;
			mux_reg     <= `DCTC_RST_MUX;
			mode_reg    <= `DCTC_MODE_NORMAL;
			mcfg_reg    <= `DCTC_RST_MCFG;
			disp_on_reg <= 1'b0;
			phase_reg   <= `DCTC_RST_PHASE;
			clock_reg   <= `DCTC_RST_CLOCK;
			prech_a_reg <= `DCTC_RST_PRECH;
			prech_b_reg <= `DCTC_RST_PRECH;
			prech_c_reg <= `DCTC_RST_PRECH;
			comh_reg    <= `DCTC_RST_COMH;
			con_a_reg   <= `DCTC_RST_CONTRAST;
			con_b_reg   <= `DCTC_RST_CONTRAST;
			con_c_reg   <= `DCTC_RST_CONTRAST;
			master_reg  <= `DCTC_RST_MASTER;
			fill_reg    <= 1'b0;
			for (i = 0; i < 32; i = i + 1)
				odd_tab_reg[i] <= 8'h01 + {i[5:0], 2'b00};
		end
		else if (CLK_EN)
		begin
			if (wr_cmd)
			begin
				case (wr_byte)
					`DCTC_CMD_ALL_OFF:  mode_reg <= `DCTC_MODE_ALL_OFF;
					`DCTC_CMD_ALL_ON:   mode_reg <= `DCTC_MODE_ALL_ON;
					`DCTC_CMD_NORMAL:   mode_reg <= `DCTC_MODE_NORMAL;
					`DCTC_CMD_INVERSE:  mode_reg <= `DCTC_MODE_INVERSE;
					`DCTC_CMD_SLEEP_ON: disp_on_reg <= 1'b0;
					`DCTC_CMD_DISP_ON:  disp_on_reg <= 1'b1;
					`DCTC_CMD_LINEAR:
					begin
						for (i = 0; i < 32; i = i + 1)
							odd_tab_reg[i] <= 8'h01 + {i[5:0], 2'b00};
					end
					default:
					begin
					end
				endcase
			end
			if (last_param)
			begin
				case (cmd_reg)
					`DCTC_CMD_OFFSET:   offset_reg <= wr_byte;
					`DCTC_CMD_MCFG:     mcfg_reg <= wr_byte[2:0];
					`DCTC_CMD_PHASE:    phase_reg <= wr_byte;
					`DCTC_CMD_CLOCK:    clock_reg <= wr_byte;
					`DCTC_CMD_COMH:     comh_reg <= wr_byte;
					`DCTC_CMD_MASTER:   master_reg <= wr_byte[3:0];
					`DCTC_CMD_FILL:     fill_reg <= wr_byte[`DCTC_FILL_BIT];
					// values under the minimum ratio are raised to it
					`DCTC_CMD_MUX:      mux_reg <= (wr_byte < `DCTC_MUX_MIN) ?
						`DCTC_MUX_MIN : wr_byte;
					`DCTC_CMD_PRECH:
					begin
						prech_a_reg <= pbuf_reg[0];
						prech_b_reg <= pbuf_reg[1];
						prech_c_reg <= wr_byte;
					end
					`DCTC_CMD_CONTRAST:
					begin
						con_a_reg <= pbuf_reg[0];
						con_b_reg <= pbuf_reg[1];
						con_c_reg <= wr_byte;
					end
					`DCTC_CMD_GRAY:
					begin
						for (i = 0; i < 31; i = i + 1)
							odd_tab_reg[i] <= stage_reg[i];
						odd_tab_reg[31] <= wr_byte;
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	// draw requests carry their parameters to the drawing engine as a one-cycle strobe
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			DRAW_LINE_STB      <= 1'b0;
			DRAW_RECT_STB      <= 1'b0;
			DRAW_FILL_EN       <= 1'b0;
			DRAW_COL_START     <= 8'h00;
			DRAW_ROW_START     <= 8'h00;
			DRAW_COL_END       <= 8'h00;
			DRAW_ROW_END       <= 8'h00;
			DRAW_OUTLINE_COLOR <= 18'h00000;
			DRAW_FILL_COLOR    <= 18'h00000;
		end
		else if (CLK_EN)
		begin
			DRAW_LINE_STB <= last_param & (cmd_reg == `DCTC_CMD_LINE);
			DRAW_RECT_STB <= last_param & (cmd_reg == `DCTC_CMD_RECT);
			if (last_param & (cmd_reg == `DCTC_CMD_LINE | cmd_reg == `DCTC_CMD_RECT))
			begin
				DRAW_COL_START <= pbuf_reg[0];
				DRAW_ROW_START <= pbuf_reg[1];
				DRAW_COL_END   <= pbuf_reg[2];
				DRAW_ROW_END   <= pbuf_reg[3];
			end
			if (last_param & (cmd_reg == `DCTC_CMD_LINE))
			begin
				DRAW_OUTLINE_COLOR <= pack_color(pbuf_reg[4], pbuf_reg[5], wr_byte);
				DRAW_FILL_EN       <= 1'b0;
			end
			if (last_param & (cmd_reg == `DCTC_CMD_RECT))
			begin
				DRAW_OUTLINE_COLOR <= pack_color(pbuf_reg[4], pbuf_reg[5], pbuf_reg[6]);
				DRAW_FILL_COLOR    <= pack_color(pbuf_reg[7], pbuf_reg[8], wr_byte);
				DRAW_FILL_EN       <= fill_reg;
			end
		end
	end

	// display clock: one enable pulse every (setting + 1) source clocks
	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_reg <= 4'h0;
			DCLK_EN     <= 1'b0;
		end
		else if (CLK_EN)
		begin
			if (div_cnt_reg >= clock_reg[3:0])
			begin
				div_cnt_reg <= 4'h0;
				DCLK_EN     <= 1'b1;
			end
			else
			begin
				div_cnt_reg <= div_cnt_reg + 4'h1;
				DCLK_EN     <= 1'b0;
			end
		end
	end

	// pixel path: override acts only on the driven value, memory data passes through untouched
	reg  [8:0]  row_sum;
	reg  [8:0]  row_mod;
	reg  [5:0]  gray_next;
	reg  [8:0]  pw_sum;
	reg  [7:0]  pw_next;

	always @*
	begin
		row_sum = {1'b0, COM_INDEX} + {1'b0, offset_reg};
		row_mod = (row_sum >= `DCTC_COMMONS) ? row_sum - `DCTC_COMMONS : row_sum;
		case (mode_reg)
			`DCTC_MODE_ALL_ON:  gray_next = `DCTC_GRAY_MAX;
			`DCTC_MODE_ALL_OFF: gray_next = 6'h00;
			`DCTC_MODE_INVERSE: gray_next = `DCTC_GRAY_MAX - PIXEL_GRAY;
			default:            gray_next = PIXEL_GRAY;
		endcase
		pw_sum = 9'h000;
		if (gray_next == 6'h00)
			pw_next = 8'h00;
		else if (gray_next[0])
			pw_next = odd_tab_reg[gray_next[5:1]];
		else
		begin
			pw_sum  = {1'b0, odd_tab_reg[gray_next[5:1] - 5'h01]} +
				{1'b0, odd_tab_reg[gray_next[5:1]]};
			pw_next = pw_sum[8:1];
		end
	end

	always @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ROW_ADDR         <= 8'h00;
			COM_ENABLE       <= 1'b0;
			DRIVE_GRAY       <= 6'h00;
			GRAY_PULSE_WIDTH <= 8'h00;
		end
		else if (CLK_EN)
		begin
			ROW_ADDR         <= row_mod[7:0];
			// rows past the ratio are not scanned, so their commons stay idle
			COM_ENABLE       <= disp_on_reg & (row_mod <= {1'b0, mux_reg}) &
				(COM_INDEX < `DCTC_COMMONS);
			DRIVE_GRAY       <= gray_next;
			GRAY_PULSE_WIDTH <= pw_next;
		end
	end

	assign OSC_INTERNAL_EN     = CLOCK_SOURCE_SELECT_PIN;
	assign OSC_FREQ_SEL        = clock_reg[7:4];
	assign RESET_PHASE_LEN     = {1'b0, phase_reg[3:0]} + 5'h01;
	assign PRECHARGE_PHASE_LEN = {1'b0, phase_reg[7:4]} + 5'h01;
	assign PANEL_ON            = disp_on_reg;
	assign BOOSTER_EN          = disp_on_reg & mcfg_reg[`DCTC_MCFG_BOOST];
	assign COMMON_HIGH_INT_EN  = disp_on_reg & mcfg_reg[`DCTC_MCFG_COMH];
	assign PRECHARGE_INT_EN    = disp_on_reg & mcfg_reg[`DCTC_MCFG_PRECH];
	assign OUTPUTS_HIZ         = ~disp_on_reg;
	assign PRECHARGE_LEVEL_A   = mcfg_reg[`DCTC_MCFG_PRECH] ? prech_a_reg : 8'h00;
	assign PRECHARGE_LEVEL_B   = mcfg_reg[`DCTC_MCFG_PRECH] ? prech_b_reg : 8'h00;
	assign PRECHARGE_LEVEL_C   = mcfg_reg[`DCTC_MCFG_PRECH] ? prech_c_reg : 8'h00;
	assign COMMON_HIGH_LEVEL   = mcfg_reg[`DCTC_MCFG_COMH] ? comh_reg : 8'h00;
	assign CONTRAST_A          = con_a_reg;
	assign CONTRAST_B          = con_b_reg;
	assign CONTRAST_C          = con_c_reg;
	assign MASTER_CURRENT      = master_reg;

endmodule // dctc_top

//--- tb/dctc_top_sva.sv
// dctc_top_sva.sv: port checks on the command and display timing block
// assumes bind onto dctc_top, a single REF_CLK domain and ARST_N low active
`timescale 1ns/1ps
module dctc_sva (
	input wire       REF_CLK,
	input wire       ARST_N,
	input wire       CLK_EN,
	input wire       WB_CYC_I,
	input wire       WB_STB_I,
	input wire       WB_ACK_O,
	input wire [7:0] COM_INDEX,
	input wire [7:0] ROW_ADDR,
	input wire       COM_ENABLE,
	input wire       DCLK_EN,
	input wire [4:0] RESET_PHASE_LEN,
	input wire [4:0] PRECHARGE_PHASE_LEN,
	input wire       PANEL_ON,
	input wire       BOOSTER_EN,
	input wire       COMMON_HIGH_INT_EN,
	input wire       PRECHARGE_INT_EN,
	input wire       OUTPUTS_HIZ,
	input wire       DRAW_LINE_STB,
	input wire       DRAW_RECT_STB
);
	reg [4:0] gap_reg;
	// saturates so a stuck divider is still seen after the count tops out
	always @(posedge REF_CLK or negedge ARST_N)
		if (!ARST_N)
			gap_reg <= 5'h00;
		else if (DCLK_EN)
			gap_reg <= 5'h00;
		else if (CLK_EN && gap_reg != 5'h1F)
			gap_reg <= gap_reg + 5'h01;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN; endsequence
	sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
	property p_ack; s_req |=> s_pulse; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_hiz; OUTPUTS_HIZ == !PANEL_ON; endproperty
	a_hiz: assert property (p_hiz) else $error("hiz mismatch");
	property p_sleep; !PANEL_ON |-> !(BOOSTER_EN || COMMON_HIGH_INT_EN || PRECHARGE_INT_EN);
	endproperty
	a_sleep: assert property (p_sleep) else $error("supply on in sleep");
	property p_phase; RESET_PHASE_LEN inside {[1:16]} && PRECHARGE_PHASE_LEN inside {[1:16]};
	endproperty
	a_phase: assert property (p_phase) else $error("phase length range");
	property p_row; ROW_ADDR < 8'd132; endproperty
	a_row: assert property (p_row) else $error("row out of range");
	property p_com; COM_ENABLE |-> $past(PANEL_ON) && $past(COM_INDEX) < 8'd132; endproperty
	a_com: assert property (p_com) else $error("common enabled wrongly");
	property p_dclk; gap_reg < 5'd20; endproperty
	a_dclk: assert property (p_dclk) else $error("display clock gap");
	property p_draw; DRAW_LINE_STB || DRAW_RECT_STB |-> WB_ACK_O || $past(WB_ACK_O); endproperty
	a_draw: assert property (p_draw) else $error("draw strobe unprompted");
	property p_line; DRAW_LINE_STB |-> !DRAW_RECT_STB ##1 !DRAW_LINE_STB; endproperty
	a_line: assert property (p_line) else $error("line strobe width");
endmodule // dctc_sva
bind dctc_top dctc_sva dctc_sva_inst (.REF_CLK, .ARST_N, .CLK_EN, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .COM_INDEX, .ROW_ADDR, .COM_ENABLE, .DCLK_EN, .RESET_PHASE_LEN,
	.PRECHARGE_PHASE_LEN, .PANEL_ON, .BOOSTER_EN, .COMMON_HIGH_INT_EN, .PRECHARGE_INT_EN,
	.OUTPUTS_HIZ, .DRAW_LINE_STB, .DRAW_RECT_STB);

//--- tb/dctc_host_model.sv
// dctc_host_model.sv: host sending command and parameter bytes over wishbone classic
// assumes the slave acks every request; slow inserts random idle cycles first
`timescale 1ns/1ps
module dctc_host_model (
	input  wire         clk,
	input  wire         ack,
	input  wire  [31:0] rdat,
	output logic [7:0]  adr,
	output logic [31:0] wdat,
	output logic [3:0]  sel,
	output logic        we,
	output logic        cyc,
	output logic        stb
);
	bit slow;
	initial {slow, adr, wdat, sel, we, cyc, stb} = '0;
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		repeat (slow ? $urandom_range(3) : 0)
			@(posedge clk);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= w ? 4'h1 : 4'hF;
		wdat <= {24'h000000, d};
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// released address and data lines never keep the last value; sel does
		adr <= ~a;
		wdat <= ~wdat;
	endtask
	task automatic cmd(input logic [7:0] c);
		logic [31:0] q;
		xfer(8'h00, 1'b1, c, q);
	endtask
	task automatic prm(input logic [7:0] p);
		logic [31:0] q;
		xfer(8'h04, 1'b1, p, q);
	endtask
endmodule // dctc_host_model

//--- tb/tb_display_command_timing_ctrl.sv
// tb_display_command_timing_ctrl.sv: self-checking bench for dctc_top
// assumes dctc_host_model as bus master and dctc_sva bound to the design
`timescale 1ns/1ps
`include "dctc_consts.vh"
module tb_display_command_timing_ctrl;
	logic        clk, arst_n = 1'b0, pin = 1'b0;
	logic [7:0]  com = 8'h00, off, d, v[10];
	logic [5:0]  gray = 6'h00;
	logic [31:0] q, r;
	wire         ack, we, cyc, stb, dclk, osc_int, on, boost, comh_en, pre_en, hiz;
	wire         com_en, lstb, rstb, fill;
	wire [7:0]   adr, row, pw, pla, plb, plc, comh, cs, rs, cend, rend, ca, cb, cc;
	wire [5:0]   drv;
	wire [4:0]   rlen, plen;
	wire [3:0]   sel, osc, mcur;
	wire [17:0]  ocol, fcol;
	wire [31:0]  wdat, rdat;
	int          n_fail, checked, i, j, n, nl, nr, gt[64];
	dctc_top dctc_top_inst (
		.REF_CLK(clk), .ARST_N(arst_n), .CLK_EN(1'b1), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .CLOCK_SOURCE_SELECT_PIN(pin), .COM_INDEX(com), .PIXEL_GRAY(gray),
		.ROW_ADDR(row), .COM_ENABLE(com_en), .DRIVE_GRAY(drv), .GRAY_PULSE_WIDTH(pw),
		.DCLK_EN(dclk), .OSC_INTERNAL_EN(osc_int), .OSC_FREQ_SEL(osc),
		.RESET_PHASE_LEN(rlen), .PRECHARGE_PHASE_LEN(plen), .PANEL_ON(on),
		.BOOSTER_EN(boost), .COMMON_HIGH_INT_EN(comh_en), .PRECHARGE_INT_EN(pre_en),
		.OUTPUTS_HIZ(hiz), .PRECHARGE_LEVEL_A(pla), .PRECHARGE_LEVEL_B(plb),
		.PRECHARGE_LEVEL_C(plc), .COMMON_HIGH_LEVEL(comh), .CONTRAST_A(ca), .CONTRAST_B(cb),
		.CONTRAST_C(cc), .MASTER_CURRENT(mcur), .DRAW_LINE_STB(lstb), .DRAW_RECT_STB(rstb),
		.DRAW_FILL_EN(fill), .DRAW_COL_START(cs), .DRAW_ROW_START(rs), .DRAW_COL_END(cend),
		.DRAW_ROW_END(rend), .DRAW_OUTLINE_COLOR(ocol), .DRAW_FILL_COLOR(fcol));
	dctc_host_model dctc_host_model_inst (.clk(clk), .ack(ack), .rdat(rdat), .adr(adr),
		.wdat(wdat), .sel(sel), .we(we), .cyc(cyc), .stb(stb));
	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		nl <= nl + (lstb === 1'b1);
		nr <= nr + (rstb === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cm(input logic [7:0] c);
		dctc_host_model_inst.cmd(c);
	endtask
	task automatic pm(input logic [7:0] p);
		dctc_host_model_inst.prm(p);
	endtask
	task automatic rd(input logic [7:0] a);
		dctc_host_model_inst.xfer(a, 1'b0, 8'h00, q);
	endtask
	task automatic send(input int cnt);
		for (int k = 0; k < cnt; k++)
		begin
			v[k] = $urandom_range(131);
			pm(v[k]);
		end
	endtask
	task automatic pix(input logic [7:0] c, input logic [5:0] g);
		@(posedge clk);
		com <= c;
		gray <= g;
		@(posedge clk);
		#1;
	endtask
	task automatic lin;
		for (int k = 0; k < 64; k++)
			gt[k] = k ? 2 * k - 1 : 0;
	endtask
	task automatic sweep;
		for (int k = 0; k < 64; k++)
		begin
			pix(8'h00, k[5:0]);
			chk(pw, gt[k], "gray width");
		end
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		i = $urandom(32'h88CA);
		repeat (20)
			@(posedge clk);
		arst_n <= 1'b1;
		repeat (3)
			@(posedge clk);
		rd(8'h0C);
		chk(q, {8'hD0, `DCTC_RST_PHASE, 8'h83, 8'h01}, "config");
		chk({hiz, mcur}, 5'h1F, "defaults");
		rd(8'h40);
		chk(q, 0, "unmapped");
		lin;
		sweep;
		$display("test defaults done");
		cm(8'hAF);
		for (i = 0; i < 4; i++)
		begin
			off = $urandom_range(131);
			d = $urandom_range(131, 15);
			cm(8'hA2);
			pm(off);
			cm(8'hCA);
			pm(d);
			j = i ? $urandom_range(131) : 131;
			pix(j[7:0], 6'h00);
			n = (j + off) % 132;
			chk(row, n, "row");
			chk(com_en, n <= d, "common enable");
		end
		for (i = 0; i < 3; i++)
		begin
			n = $urandom_range(63);
			cm(8'hA4 + i + (i == 2));
			pix(8'h05, n[5:0]);
			chk(drv, i == 0 ? 0 : (i == 1 ? 63 : 63 - n), "override");
			cm(8'hA6);
			pix(8'h05, n[5:0]);
			chk(drv, n, "normal");
		end
		$display("test mapping done");
		r = $urandom;
		cm(8'hBB);
		for (i = 0; i < 3; i++)
			pm(r[8 * i +: 8]);
		cm(8'hBE);
		pm(r[31:24]);
		for (i = 0; i < 8; i++)
		begin
			cm(8'hAD);
			pm(i[7:0]);
			#1;
			chk({boost, comh_en, pre_en}, {i[0], i[1], i[2]}, "selects");
			chk({pla, plb, plc, comh}, {i[2] ? {r[7:0], r[15:8], r[23:16]} : 24'h000000,
				i[1] ? r[31:24] : 8'h00}, "levels");
		end
		cm(8'hAE);
		#1;
		chk({hiz, on, boost, comh_en, pre_en}, 5'h10, "sleep");
		cm(8'hAF);
		for (i = 0; i < 3; i++)
		begin
			d = i == 0 ? 8'hFF : (i == 1 ? 8'h00 : $urandom);
			pin <= i[0];
			cm(8'hB1);
			pm(d);
			cm(8'hB3);
			pm(d);
			#1;
			chk({rlen, plen}, {d[3:0] + 5'd1, d[7:4] + 5'd1}, "phases");
			chk({osc, osc_int}, {d[7:4], i[0]}, "oscillator");
			repeat (40)
				@(posedge clk);
			for (n = 0; n < 40 && dclk !== 1'b1; n++)
				@(posedge clk);
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (dclk !== 1'b1 && n < 40);
			chk(n, d[3:0] + 1, "dclk period");
		end
		$display("test supplies done");
		dctc_host_model_inst.slow = 1'b1;
		cm(8'hB8);
		n = 0;
		for (i = 1; i < 64; i += 2)
		begin
			n += 2 + $urandom_range(1);
			gt[i] = n;
			pm(n[7:0]);
		end
		for (i = 2; i < 63; i += 2)
			gt[i] = (gt[i - 1] + gt[i + 1]) / 2;
		sweep;
		cm(8'hB9);
		lin;
		sweep;
		dctc_host_model_inst.slow = 1'b0;
		r = $urandom;
		cm(8'hC1);
		for (i = 0; i < 3; i++)
			pm(r[8 * i +: 8]);
		cm(8'hC7);
		pm({4'h0, r[27:24]});
		rd(8'h10);
		chk(q, {off, r[23:0]}, "contrast");
		chk({ca, cb, cc}, {r[7:0], r[15:8], r[23:16]}, "contrast outputs");
		chk(mcur, r[27:24], "master");
		$display("test gray done");
		cm(8'h83);
		pm(8'h01);
		cm(8'h83);
		send(7);
		repeat (3)
			@(posedge clk);
		chk(nl, 1, "line count");
		chk({cs, rs, cend, rend}, {v[0], v[1], v[2], v[3]}, "line corners");
		chk(ocol, {v[4][5:0], v[5][5:0], v[6][5:0]}, "line colour");
		for (j = 1; j >= 0; j--)
		begin
			cm(8'h92);
			pm(j[7:0]);
			cm(8'h84);
			send(10);
			repeat (3)
				@(posedge clk);
			chk({fill, fcol}, {j[0], v[7][5:0], v[8][5:0], v[9][5:0]}, "fill");
			chk({cs, rs, cend, rend}, {v[0], v[1], v[2], v[3]}, "rect corners");
			chk(ocol, {v[4][5:0], v[5][5:0], v[6][5:0]}, "rect outline");
		end
		chk(nr, 2, "rect count");
		$display("test draw done");
		complete_run;
	end
	initial
	begin
		repeat (30000)
			@(posedge clk);
		n_fail++;
		$display("Error watchdog expired");
		complete_run;
	end
endmodule // tb_display_command_timing_ctrl
